// File: hw/csb_cmd_slave.sv
`timescale 1ns/1ps
// How it works
// - All link items are 16-bit words
// - Works in serial modes 0 and 3
// - Data out driven only while frame low
// - First word after frame start is command
// - Frame end aborts any command in progress
// - Opcodes 1..4: write, read, burst write/read
// - Address reaches whole bus memory map
// - Burst second word is length, max 8191
// - Single write stores second word, then commands
// - Single read: dummy, then data third word
// - Burst write stores successive words to length
// - Burst read returns successive words to length
// - Bus master reaches RAM and register space
// - Bus shared with DMA without stalling
// - Interface masters bus single or burst
// - Shared 4 kB RAM reachable by commands
module csb_cmd_slave
	import csb_pkg::*;
#(
	parameter int RAM_WORDS = CSB_RAM_WORDS
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        serial_clk,
	input  wire logic        serial_frame_n,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	output csb_bus_req_t     reg_bus,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        dma_bus_busy,
	output logic             cmd_error
);
	// Two-stage synchronisers; stage one feeds only stage two
	logic [1:0] sclk_sync_reg, fr_sync_reg, din_sync_reg;
	logic       sclk_d_reg, fr_d_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_sync_reg <= 2'h0;
			fr_sync_reg   <= 2'h3;
			din_sync_reg  <= 2'h0;
			sclk_d_reg    <= 1'b0;
			fr_d_reg      <= 1'b1;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], serial_clk};
			fr_sync_reg   <= {fr_sync_reg[0], serial_frame_n};
			din_sync_reg  <= {din_sync_reg[0], serial_data_in};
			sclk_d_reg    <= sclk_sync_reg[1];
			fr_d_reg      <= fr_sync_reg[1];
		end
	end

	wire sclk_s    = sclk_sync_reg[1];
	wire frame_n_s = fr_sync_reg[1];
	wire din_s     = din_sync_reg[1];
	// Modes 0 and 3 both sample on rising, shift on falling
	wire rise      = sclk_s & ~sclk_d_reg & ~frame_n_s;
	wire fall      = ~sclk_s & sclk_d_reg & ~frame_n_s;
	wire fr_start  = ~frame_n_s & fr_d_reg;
	wire fr_end    = frame_n_s & ~fr_d_reg;

	// Shared RAM, lower part of the map; rest goes to registers
	logic [15:0] ram_mem [RAM_WORDS];

	logic [3:0]  bit_cnt_reg;
	logic [15:0] shift_in_reg;
	logic [15:0] shift_out_reg;
	logic [15:0] rdata_reg;
	logic [12:0] addr_reg;
	logic [12:0] len_reg;
	logic        rd_pend_reg;
	logic        out_reg;
	logic        oe_reg;
	logic        err_reg;
	csb_state_t  state_reg, state_next;
	csb_bus_req_t bus_reg;

	wire         word_done = rise & (bit_cnt_reg == CSB_LAST_BIT);
	wire [15:0]  word_in   = {shift_in_reg[14:0], din_s};
	wire [2:0]   op_in     = word_in[CSB_OP_MSB:CSB_OP_LSB];
	wire [12:0]  addr_in   = word_in[CSB_ADDR_W-1:0];
	wire         in_ram    = addr_reg <= CSB_RAM_TOP;
	wire [12:0]  addr_inc  = 13'(addr_reg + 13'h0001);
	wire [12:0]  len_dec   = 13'(len_reg - 13'h0001);
	wire         len_last  = len_reg == 13'h0001;
	wire         len_zero  = word_in[12:0] == CSB_LEN_RST;
	wire         load_out  = fall & (bit_cnt_reg == 4'h0);
	wire         is_wr_st  = (state_reg == CSB_ST_WDATA) |
	                         (state_reg == CSB_ST_BWR);
	wire         do_write  = word_done & is_wr_st;
	// Fetch next word on the last rising edge of the word before it is shifted out
	wire         do_fetch  = word_done &
	                         ((state_reg == CSB_ST_DUMMY) |
	                          (state_reg == CSB_ST_LEN &
	                           state_next == CSB_ST_BRD) |
	                          (state_reg == CSB_ST_BRD & ~len_last));

	always_comb begin
		state_next = state_reg;
		if (word_done) begin
			case (state_reg)
				CSB_ST_CMD, CSB_ST_IDLE: begin
					case (op_in)
						CSB_OP_WR:  state_next = CSB_ST_WDATA;
						CSB_OP_RD:  state_next = CSB_ST_DUMMY;
						CSB_OP_BWR,
						CSB_OP_BRD: state_next = CSB_ST_LEN;
						default:    state_next = CSB_ST_CMD;
					endcase
				end
				CSB_ST_WDATA: state_next = CSB_ST_CMD;
				CSB_ST_DUMMY: state_next = CSB_ST_IDLE;
				CSB_ST_LEN: begin
					if (len_zero)
						state_next = CSB_ST_CMD;
					else if (op_in == CSB_OP_BRD)
						state_next = CSB_ST_CMD;
					else
						state_next = CSB_ST_CMD;
					if (!len_zero)
						state_next = rd_pend_reg ? CSB_ST_BRD : CSB_ST_BWR;
				end
				CSB_ST_BWR, CSB_ST_BRD: begin
					if (len_last)
						state_next = CSB_ST_CMD;
				end
				default: state_next = CSB_ST_CMD;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg    <= CSB_ST_CMD;
			bit_cnt_reg  <= 4'h0;
			shift_in_reg <= CSB_WORD_RST;
			addr_reg     <= 13'h0000;
			len_reg      <= CSB_LEN_RST;
			rd_pend_reg  <= 1'b0;
			err_reg      <= 1'b0;
		end else if (fr_start | fr_end) begin
			state_reg   <= CSB_ST_CMD;
			bit_cnt_reg <= 4'h0;
		end else if (rise) begin
			state_reg    <= state_next;
			bit_cnt_reg  <= 4'(bit_cnt_reg + 4'h1);
			shift_in_reg <= word_in;
			if (word_done) begin
				case (state_reg)
					CSB_ST_CMD, CSB_ST_IDLE: begin
						addr_reg    <= addr_in;
						rd_pend_reg <= op_in == CSB_OP_BRD;
						err_reg     <= state_next == CSB_ST_CMD;
					end
					// Burst read fetches one word ahead, so address leads
					CSB_ST_LEN: begin
						len_reg <= word_in[12:0];
						if (state_next == CSB_ST_BRD)
							addr_reg <= addr_inc;
					end
					CSB_ST_WDATA: addr_reg <= addr_reg;
					CSB_ST_BWR: begin
						addr_reg <= addr_inc;
						len_reg  <= len_dec;
					end
					CSB_ST_BRD: begin
						addr_reg <= addr_inc;
						len_reg  <= len_dec;
					end
					default: addr_reg <= addr_reg;
				endcase
			end
		end
	end

	// Bus side; DMA traffic never blocks these one-cycle accesses
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bus_reg   <= '0;
			rdata_reg <= CSB_WORD_RST;
		end else begin
			bus_reg.req   <= (do_write | do_fetch) & ~in_ram;
			bus_reg.we    <= do_write;
			bus_reg.addr  <= addr_reg;
			bus_reg.wdata <= word_in;
			if (do_fetch & in_ram)
				rdata_reg <= ram_mem[addr_reg[10:0]];
			else if (bus_reg.req & ~bus_reg.we)
				rdata_reg <= reg_rdata;
		end
	end

	// RAM has no reset; contents undefined until written
	always_ff @(posedge clk_sys) begin
		if (do_write & in_ram)
			ram_mem[addr_reg[10:0]] <= word_in;
	end

	wire send_data = (state_reg == CSB_ST_IDLE & rd_pend_reg == 1'b0) |
	                 (state_reg == CSB_ST_BRD);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shift_out_reg <= CSB_WORD_RST;
			out_reg       <= 1'b0;
			oe_reg        <= 1'b0;
		end else begin
			oe_reg <= ~frame_n_s;
			if (frame_n_s) begin
				out_reg       <= 1'b0;
				shift_out_reg <= CSB_WORD_RST;
			end else if (load_out) begin
				shift_out_reg <= send_data ? {rdata_reg[14:0], 1'b0}
				                           : CSB_WORD_RST;
				out_reg       <= send_data & rdata_reg[15];
			end else if (fall) begin
				shift_out_reg <= {shift_out_reg[14:0], 1'b0};
				out_reg       <= shift_out_reg[15];
			end
		end
	end

	assign serial_data_out = out_reg;
	assign serial_data_oe  = oe_reg;
	assign reg_bus         = bus_reg;
	assign cmd_error       = err_reg;

	chk_frame_oe_follow: assert property (@(posedge clk_sys)
		disable iff (sys_rst) frame_n_s |=> !serial_data_oe)
		else $error("data out driven outside frame");
	chk_end_aborts: assert property (@(posedge clk_sys)
		disable iff (sys_rst) fr_end |=> state_reg == CSB_ST_CMD)
		else $error("frame end did not abort command");
	chk_wr_opcode: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && state_reg == CSB_ST_CMD && op_in == CSB_OP_WR
		&& !fr_start && !fr_end |=> state_reg == CSB_ST_WDATA)
		else $error("write opcode not decoded");
	chk_cmd_zero_out: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		load_out && state_reg == CSB_ST_CMD |=> !serial_data_out)
		else $error("command word output not zero");
	chk_burst_len_dec: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && state_reg == CSB_ST_BWR && !fr_start && !fr_end
		|=> len_reg == $past(len_reg) - 13'h0001)
		else $error("burst length not counted");
	chk_burst_stop: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && state_reg == CSB_ST_BRD && len_last
		|=> state_reg == CSB_ST_CMD)
		else $error("burst read did not stop");
	chk_single_wr_back: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && state_reg == CSB_ST_WDATA |=> state_reg == CSB_ST_CMD)
		else $error("single write did not return");
	chk_reg_write: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		do_write && !in_ram |=> reg_bus.req && reg_bus.we
		&& reg_bus.addr == $past(addr_reg))
		else $error("register write not issued");
	chk_word_len: assert property (@(posedge clk_sys)
		disable iff (sys_rst) word_done |=> bit_cnt_reg == 4'h0)
		else $error("word not 16 bits");
	chk_rd_dma_ok: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		reg_bus.req && !reg_bus.we && dma_bus_busy |=> rdata_reg == $past(reg_rdata))
		else $error("register read lost while other master busy");
	chk_brd_addr_step: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && state_reg == CSB_ST_BRD && !fr_start
		|=> addr_reg == $past(addr_reg) + 13'h0001)
		else $error("burst read address not stepped");
	chk_dummy_to_data: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && state_reg == CSB_ST_DUMMY && !fr_start
		|=> state_reg == CSB_ST_IDLE)
		else $error("single read did not reach data word");
	chk_err_unknown: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && !fr_start && op_in == 3'h0 &&
		(state_reg == CSB_ST_CMD || state_reg == CSB_ST_IDLE) |=> cmd_error)
		else $error("unknown opcode not flagged");
	chk_len_zero_skip: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		word_done && state_reg == CSB_ST_LEN && len_zero && !fr_start
		|=> state_reg == CSB_ST_CMD)
		else $error("zero length burst not skipped");
	chk_idle_out_low: assert property (@(posedge clk_sys)
		disable iff (sys_rst) frame_n_s |=> !serial_data_out)
		else $error("data out not low outside frame");


	cov_single_rd: cover property (@(posedge clk_sys)
		word_done && state_reg == CSB_ST_DUMMY);
	cov_burst_wr: cover property (@(posedge clk_sys)
		do_write && state_reg == CSB_ST_BWR);
	cov_burst_rd_end: cover property (@(posedge clk_sys)
		word_done && state_reg == CSB_ST_BRD && len_last);
	cov_abort: cover property (@(posedge clk_sys)
		fr_end && state_reg == CSB_ST_BWR);
	cov_reg_read_busy: cover property (@(posedge clk_sys)
		reg_bus.req && !reg_bus.we && dma_bus_busy);
endmodule

// File: hw/csb_pkg.sv
package csb_pkg;
	localparam int          CSB_WORD_W     = 16;
	localparam int          CSB_ADDR_W     = 13;
	localparam int          CSB_OP_MSB     = 15;
	localparam int          CSB_OP_LSB     = 13;
	localparam int          CSB_CNT_W      = 4;
	localparam logic [3:0]  CSB_LAST_BIT   = 4'hf;
	localparam logic [12:0] CSB_MAX_LEN    = 13'h1fff;
	localparam int          CSB_RAM_BYTES  = 4096;
	localparam int          CSB_RAM_WORDS  = CSB_RAM_BYTES / 2;
	localparam logic [12:0] CSB_RAM_TOP    = 13'h07ff;
	localparam logic [12:0] CSB_LEN_RST    = 13'h0000;
	localparam logic [15:0] CSB_WORD_RST   = 16'h0000;

	typedef enum logic [2:0] {
		CSB_OP_WR  = 3'h1,
		CSB_OP_RD  = 3'h2,
		CSB_OP_BWR = 3'h3,
		CSB_OP_BRD = 3'h4
	} csb_op_t;

	typedef enum logic [2:0] {
		CSB_ST_CMD   = 3'h0,
		CSB_ST_WDATA = 3'h1,
		CSB_ST_DUMMY = 3'h2,
		CSB_ST_LEN   = 3'h3,
		CSB_ST_BWR   = 3'h4,
		CSB_ST_BRD   = 3'h5,
		CSB_ST_IDLE  = 3'h6
	} csb_state_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [12:0] addr;
		logic [15:0] wdata;
	} csb_bus_req_t;
endpackage

// File: verification/csb_cmd_slave_tb.sv
`timescale 1ns/1ps
module csb_cmd_slave_tb;
	import csb_pkg::*;
	logic         clk_sys;
	logic         sys_rst;
	logic         serial_clk, serial_frame_n, serial_data_in;
	logic         serial_data_out, serial_data_oe, cmd_error;
	logic         dma_bus_busy = 1'b0;
	logic         dma_hold = 1'b0;
	logic [15:0]  lfsr = 16'h0038;
	logic [15:0]  reg_rdata, rx;
	logic [15:0]  shadow [0:4];
	csb_bus_req_t reg_bus;
	csb_bus_req_t last_req = '0;
	int           fails, samples_checked;

	csb_cmd_slave u_csb_cmd_slave (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.serial_clk(serial_clk), .serial_frame_n(serial_frame_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe), .reg_bus(reg_bus),
		.reg_rdata(reg_rdata), .dma_bus_busy(dma_bus_busy),
		.cmd_error(cmd_error));
	csb_host_model u_csb_host_model (.serial_clk(serial_clk),
		.serial_frame_n(serial_frame_n), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out));

	function automatic logic [15:0] lfsr_next(input logic [15:0] l);
		return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
	endfunction
	function automatic logic [15:0] cmd(input logic [2:0] op,
		input logic [12:0] a);
		return {op, a};
	endfunction
	function automatic logic [15:0] reg_model(input logic [12:0] a);
		return {3'h5, a};
	endfunction

	// Random bus ownership by the other master while commands run
	always @(posedge clk_sys) begin
		lfsr         <= lfsr_next(lfsr);
		dma_bus_busy <= lfsr[3] | dma_hold;
		if (reg_bus.req) begin
			last_req <= reg_bus;
		end
	end
	// Register space answers in the cycle its request stands
	assign reg_rdata = reg_model(reg_bus.addr);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatched %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic send(input logic [15:0] t);
		u_csb_host_model.xfer(t, rx);
	endtask
	task automatic begin_frame();
		u_csb_host_model.open_frame();
		check({15'h0000, serial_data_oe}, 16'h0001);
	endtask
	task automatic end_frame(input int n);
		u_csb_host_model.close_frame();
		check({15'h0000, serial_data_oe}, 16'h0000);
		$display("test %0d done", n);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		fails++;
		complete_run();
	end
	initial begin
		sys_rst = 1'b1;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		// Writes, then chained reads whose third word is the next command
		for (int m = 0; m < 2; m++) begin
			u_csb_host_model.mode3 = m[0];
			begin_frame();
			for (int i = 0; i < 4; i++) begin
				shadow[i] = lfsr;
				send(cmd(CSB_OP_WR, 13'h0010 + 13'(i)));
				check(rx, 16'h0000);
				send(shadow[i]);
			end
			send(cmd(CSB_OP_RD, 13'h0010));
			for (int i = 1; i < 5; i++) begin
				send(16'h0000);
				check(rx, 16'h0000);
				send(i < 4 ? cmd(CSB_OP_RD, 13'h0010 + 13'(i)) : 16'h0000);
				check(rx, shadow[i-1]);
			end
			repeat (8) @(posedge clk_sys);
			check({15'h0000, cmd_error}, 16'h0001);
			end_frame(m);
		end
		// Burst write, burst read, then commands riding after the burst
		u_csb_host_model.switch_gap();
		begin_frame();
		send(cmd(CSB_OP_BWR, 13'h0100));
		send(16'h0005);
		check({15'h0000, cmd_error}, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			shadow[i] = lfsr;
			send(shadow[i]);
		end
		send(cmd(CSB_OP_BRD, 13'h0100));
		send(16'h0005);
		check(rx, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			send(16'h0000);
			check(rx, shadow[i]);
		end
		send(cmd(CSB_OP_RD, 13'h0102));
		send(16'h0000);
		send(cmd(CSB_OP_WR, 13'h1234));
		check(rx, shadow[2]);
		send(16'hbeef);
		// Other master owns the bus for the whole register read
		dma_hold <= 1'b1;
		send(cmd(CSB_OP_RD, 13'h1300));
		check(last_req.we ? last_req.wdata : 16'h0000, 16'hbeef);
		check({3'h0, last_req.addr}, 16'h1234);
		send(16'h0000);
		send(cmd(CSB_OP_WR, 13'h0200));
		check(rx, reg_model(13'h1300));
		dma_hold <= 1'b0;
		send(lfsr);
		end_frame(2);
		// Frame end cuts a burst write short
		begin_frame();
		send(cmd(CSB_OP_BWR, 13'h0100));
		send(16'h0005);
		send(~shadow[0]);
		send(~shadow[1]);
		end_frame(3);
		begin_frame();
		send(cmd(CSB_OP_BRD, 13'h0100));
		send(16'h0005);
		for (int i = 0; i < 5; i++) begin
			send(16'h0000);
			check(rx, i < 2 ? ~shadow[i] : shadow[i]);
		end
		end_frame(4);
		complete_run();
	end
endmodule

// File: verification/csb_host_model.sv
`timescale 1ns/1ps
module csb_host_model (
	output logic      serial_clk,
	output logic      serial_frame_n,
	output logic      serial_data_in,
	input  wire logic serial_data_out
);
	logic mode3 = 1'b0;
	initial begin
		serial_clk     = 1'b0;
		serial_frame_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// Clock idles at the mode's level and stands still between frames
	task automatic open_frame();
		serial_clk <= mode3;
		#100 serial_frame_n <= 1'b0;
		#100;
	endtask
	// Quiet gap after a system clock switch, clock held still
	task automatic switch_gap();
		#3200;
	endtask
	// Inverting the data line so no stale bit looks valid after release
	task automatic close_frame();
		#100 serial_frame_n <= 1'b1;
		serial_clk     <= mode3;
		serial_data_in <= ~serial_data_in;
		#400;
	endtask
	// 200 ns period keeps the link far under half the system clock
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		for (int i = 15; i >= 0; i--) begin
			serial_clk     <= 1'b0;
			serial_data_in <= tx[i];
			#100 rx[i] = serial_data_out;
			serial_clk <= 1'b1;
			#100;
		end
	endtask
endmodule
